//--- hw/tcp_cfg_host.sv
// Initiating end of the configuration port: turns user requests into accesses.
// Assumes the device answers each access with one ready pulse on its channel.
// Each channel keeps one access in flight; a request offered while it is busy
// is dropped, not queued, so the user must wait for req_ready.
// A device that never answers is cut off by a timeout, so that a broken channel
// cannot hold its user forever.
module tcp_cfg_host #(
	parameter int TIMEOUT_CYCLES = tcp_pkg::DEF_TIMEOUT_CYCLES
) (
	input  wire logic                                          sys_clk,
	input  wire logic                                          rst_n,
	tcp_cfg_if.usr                                             cfg,
	input  wire logic [tcp_pkg::NUM_CH-1:0]                    req_valid,
	output logic      [tcp_pkg::NUM_CH-1:0]                    req_ready,
	input  wire logic [tcp_pkg::NUM_CH-1:0]                    req_write,
	input  wire logic [tcp_pkg::NUM_CH-1:0][tcp_pkg::ADDR_W-1:0] req_address,
	input  wire logic [tcp_pkg::NUM_CH-1:0][tcp_pkg::DATA_W-1:0] req_write_data,
	output logic      [tcp_pkg::NUM_CH-1:0]                    resp_valid,
	output logic      [tcp_pkg::NUM_CH-1:0]                    resp_was_write,
	output logic      [tcp_pkg::NUM_CH-1:0]                    resp_timeout,
	output logic      [tcp_pkg::NUM_CH-1:0][tcp_pkg::DATA_W-1:0] resp_read_data
);

	localparam int NC = tcp_pkg::NUM_CH;
	localparam int AW = tcp_pkg::ADDR_W;
	localparam int DW = tcp_pkg::DATA_W;
	// Last timer value before an access is given up.
	localparam logic [tcp_pkg::CNT_W-1:0] TIMER_LAST = tcp_pkg::CNT_W'(TIMEOUT_CYCLES - 1);

	if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 65535) begin : g_bad_timeout
		$error("TIMEOUT_CYCLES must lie between 1 and 65535");
	end

	// The timeout must outlast the device's answer, or every access would time out.
	if (TIMEOUT_CYCLES <= tcp_pkg::DEF_ACCESS_LATENCY + 1) begin : g_short_timeout
		$error("TIMEOUT_CYCLES must exceed the access latency plus one");
	end

	// The carrier wires exactly two channels by name.
	if (tcp_pkg::NUM_CH != 2) begin : g_bad_channels
		$error("NUM_CH must be 2 to match the carrier");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		// Channel phase and the direction of the access in flight.
		tcp_pkg::tcp_state_t        state;
		logic                       write;
		// Cycles spent waiting for ready.
		logic [tcp_pkg::CNT_W-1:0]  timer;
		// Strobes and operands presented to the device.
		logic                       en;
		logic                       we;
		logic [AW-1:0]              addr;
		logic [DW-1:0]              wdata;
		// Response towards the user.
		logic                       rvalid;
		logic                       rtimeout;
		logic [DW-1:0]              rdata;
	} tcp_hch_t;

	typedef struct packed {
		tcp_hch_t [NC-1:0] ch;
	} tcp_hstate_t;

	tcp_hstate_t st_q;
	tcp_hstate_t st_d;

	// ------------------------------------------------------------------
	// Value after reset
	// ------------------------------------------------------------------
	// Strobes and responses start low; operands start at zero.
	localparam tcp_hch_t RST_CH = '{
		state:    tcp_pkg::TCP_IDLE,
		write:    1'b0,
		timer:    tcp_pkg::RST_CNT,
		en:       1'b0,
		we:       1'b0,
		addr:     tcp_pkg::RST_ADDR,
		wdata:    tcp_pkg::RST_DATA,
		rvalid:   1'b0,
		rtimeout: 1'b0,
		rdata:    tcp_pkg::RST_DATA
	};

	// ------------------------------------------------------------------
	// Port inputs gathered per channel
	// ------------------------------------------------------------------
	logic [NC-1:0]         rdy_i;
	logic [NC-1:0][DW-1:0] rdata_i;

	assign rdy_i   = {cfg.ch1_cfg_ready, cfg.ch0_cfg_ready};
	assign rdata_i = {cfg.ch1_cfg_read_data, cfg.ch0_cfg_read_data};

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < NC; i++) begin
			// Enable is a strobe: whatever was launched last cycle drops now.
			st_d.ch[i].en     = 1'b0;
			st_d.ch[i].we     = 1'b0;
			st_d.ch[i].rvalid = 1'b0;
			unique case (st_q.ch[i].state)
				tcp_pkg::TCP_IDLE: begin
					// Operands are latched here and held until the next request.
					if (req_valid[i]) begin
						st_d.ch[i].state    = tcp_pkg::TCP_BUSY;
						st_d.ch[i].en       = 1'b1;
						st_d.ch[i].we       = req_write[i];
						st_d.ch[i].write    = req_write[i];
						st_d.ch[i].addr     = req_address[i];
						st_d.ch[i].wdata    = req_write_data[i];
						st_d.ch[i].timer    = tcp_pkg::RST_CNT;
					end
				end
				tcp_pkg::TCP_BUSY: begin
					if (rdy_i[i]) begin
						st_d.ch[i].state    = tcp_pkg::TCP_IDLE;
						st_d.ch[i].rvalid   = 1'b1;
						st_d.ch[i].rtimeout = 1'b0;
						// A write leaves the last read word in place.
						if (!st_q.ch[i].write) begin
							st_d.ch[i].rdata = rdata_i[i];
						end
					end else if (st_q.ch[i].timer == TIMER_LAST) begin
						// A channel that never answers must not lock the user out.
						st_d.ch[i].state    = tcp_pkg::TCP_IDLE;
						st_d.ch[i].rvalid   = 1'b1;
						st_d.ch[i].rtimeout = 1'b1;
					end else begin
						// The timer counts the cycles since the strobe went out.
						st_d.ch[i].timer = tcp_pkg::CNT_W'(st_q.ch[i].timer + 1'b1);
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers, all on the one port clock
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Reset clears the strobes at once, so no access leaks out while rst_n is low.
			for (int i = 0; i < NC; i++) begin
				st_q.ch[i] <= RST_CH;
			end
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Port outputs
	// ------------------------------------------------------------------
	// Address and write data stay on the last access after the strobe ends,
	// so the device may sample them at any point of its busy time.
	logic [NC-1:0]         en_o;
	logic [NC-1:0]         we_o;
	logic [NC-1:0][AW-1:0] addr_o;
	logic [NC-1:0][DW-1:0] wdata_o;

	always_comb begin
		for (int i = 0; i < NC; i++) begin
			en_o[i]    = st_q.ch[i].en;
			we_o[i]    = st_q.ch[i].we;
			addr_o[i]  = st_q.ch[i].addr;
			wdata_o[i] = st_q.ch[i].wdata;
		end
	end

	assign cfg.ch0_cfg_access_enable = en_o[0];
	assign cfg.ch0_cfg_write_select  = we_o[0];
	assign cfg.ch0_cfg_address       = addr_o[0];
	assign cfg.ch0_cfg_write_data    = wdata_o[0];
	assign cfg.ch1_cfg_access_enable = en_o[1];
	assign cfg.ch1_cfg_write_select  = we_o[1];
	assign cfg.ch1_cfg_address       = addr_o[1];
	assign cfg.ch1_cfg_write_data    = wdata_o[1];

	// ------------------------------------------------------------------
	// User outputs
	// ------------------------------------------------------------------
	// A ready that arrives after the timeout has fired is dropped, because
	// the channel is idle again; a late answer cannot be told apart from
	// the next access, so the timeout should exceed the device latency.
	always_comb begin
		for (int i = 0; i < NC; i++) begin
			req_ready[i]      = (st_q.ch[i].state == tcp_pkg::TCP_IDLE);
			resp_valid[i]     = st_q.ch[i].rvalid;
			resp_was_write[i] = st_q.ch[i].write;
			resp_timeout[i]   = st_q.ch[i].rtimeout;
			resp_read_data[i] = st_q.ch[i].rdata;
		end
	end

endmodule // tcp_cfg_host

//--- hw/tcp_pkg.sv
// Shared constants and types for the transceiver configuration port.
// Assumes both ends and the bench run on one clock, the configuration port clock.
package tcp_pkg;

	// ------------------------------------------------------------------
	// Port geometry
	// ------------------------------------------------------------------
	localparam int NUM_CH = 2;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int DEPTH  = 1 << ADDR_W;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam real CLK_PERIOD_NS       = 10.0;
	// Busy cycles the channel spends after taking an access, before ready.
	localparam int  DEF_ACCESS_LATENCY  = 2;
	// Longest wait for ready before the initiator gives up, in nanoseconds.
	localparam real TIMEOUT_NS          = 640.0;
	localparam int  DEF_TIMEOUT_CYCLES  = $rtoi(TIMEOUT_NS / CLK_PERIOD_NS);
	localparam int  CNT_W               = 16;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] RST_ADDR = 10'h000;
	localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
	localparam logic [CNT_W-1:0]  RST_CNT  = 16'h0000;

	// ------------------------------------------------------------------
	// Per-channel states
	// ------------------------------------------------------------------
	typedef enum logic [0:0] {
		TCP_IDLE = 1'b0,
		TCP_BUSY = 1'b1
	} tcp_state_t;

endpackage

//--- hw/tcp_cfg_if.sv
// Interface joining the initiating fabric logic to the configuration port.
// Assumes both parties are clocked by the same configuration port clock.
interface tcp_cfg_if;

	logic                        ch0_cfg_access_enable;
	logic                        ch0_cfg_write_select;
	logic [tcp_pkg::ADDR_W-1:0]  ch0_cfg_address;
	logic [tcp_pkg::DATA_W-1:0]  ch0_cfg_write_data;
	logic [tcp_pkg::DATA_W-1:0]  ch0_cfg_read_data;
	logic                        ch0_cfg_ready;
	logic                        ch1_cfg_access_enable;
	logic                        ch1_cfg_write_select;
	logic [tcp_pkg::ADDR_W-1:0]  ch1_cfg_address;
	logic [tcp_pkg::DATA_W-1:0]  ch1_cfg_write_data;
	logic [tcp_pkg::DATA_W-1:0]  ch1_cfg_read_data;
	logic                        ch1_cfg_ready;

	modport dev (
		input  ch0_cfg_access_enable,
		input  ch0_cfg_write_select,
		input  ch0_cfg_address,
		input  ch0_cfg_write_data,
		output ch0_cfg_read_data,
		output ch0_cfg_ready,
		input  ch1_cfg_access_enable,
		input  ch1_cfg_write_select,
		input  ch1_cfg_address,
		input  ch1_cfg_write_data,
		output ch1_cfg_read_data,
		output ch1_cfg_ready
	);

	modport usr (
		output ch0_cfg_access_enable,
		output ch0_cfg_write_select,
		output ch0_cfg_address,
		output ch0_cfg_write_data,
		input  ch0_cfg_read_data,
		input  ch0_cfg_ready,
		output ch1_cfg_access_enable,
		output ch1_cfg_write_select,
		output ch1_cfg_address,
		output ch1_cfg_write_data,
		input  ch1_cfg_read_data,
		input  ch1_cfg_ready
	);

endinterface

//--- hw/tcp_cfg_dev.sv
// Device end of the configuration port: per-channel configuration space.
// Assumes the initiator raises enable for one cycle and waits for ready.
module tcp_cfg_dev #(
	parameter int ACCESS_LATENCY = tcp_pkg::DEF_ACCESS_LATENCY
) (
	input  wire logic                                          sys_clk,
	input  wire logic                                          rst_n,
	tcp_cfg_if.dev                                             cfg,
	output logic [tcp_pkg::NUM_CH-1:0]                         ch_busy,
	output logic [tcp_pkg::NUM_CH-1:0]                         upd_valid,
	output logic [tcp_pkg::NUM_CH-1:0][tcp_pkg::ADDR_W-1:0]    upd_address,
	output logic [tcp_pkg::NUM_CH-1:0][tcp_pkg::DATA_W-1:0]    upd_data
);

	localparam int NC = tcp_pkg::NUM_CH;
	localparam int AW = tcp_pkg::ADDR_W;
	localparam int DW = tcp_pkg::DATA_W;

	if (ACCESS_LATENCY < 1 || ACCESS_LATENCY > 65535) begin : g_bad_latency
		$error("ACCESS_LATENCY must lie between 1 and 65535");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		tcp_pkg::tcp_state_t        state;
		logic                       write;
		logic [tcp_pkg::CNT_W-1:0]  cnt;
		logic [AW-1:0]              addr;
		logic                       rdy;
		logic [DW-1:0]              rdata;
		logic                       upd;
		logic [DW-1:0]              wdata;
	} tcp_dch_t;

	typedef struct packed {
		tcp_dch_t [NC-1:0] ch;
	} tcp_dstate_t;

	tcp_dstate_t st_q;
	tcp_dstate_t st_d;

	// Storage is kept outside the state record; it has no reset value.
	logic [DW-1:0] mem [NC][tcp_pkg::DEPTH];

	logic [NC-1:0]         en_i;
	logic [NC-1:0]         we_i;
	logic [NC-1:0][AW-1:0] addr_i;
	logic [NC-1:0][DW-1:0] wdata_i;

	assign en_i    = {cfg.ch1_cfg_access_enable, cfg.ch0_cfg_access_enable};
	assign we_i    = {cfg.ch1_cfg_write_select, cfg.ch0_cfg_write_select};
	assign addr_i  = {cfg.ch1_cfg_address, cfg.ch0_cfg_address};
	assign wdata_i = {cfg.ch1_cfg_write_data, cfg.ch0_cfg_write_data};

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < NC; i++) begin
			st_d.ch[i].rdy = 1'b0;
			st_d.ch[i].upd = 1'b0;
			unique case (st_q.ch[i].state)
				tcp_pkg::TCP_IDLE: begin
					// An enable seen while busy is ignored; the initiator must wait.
					if (en_i[i]) begin
						st_d.ch[i].state = tcp_pkg::TCP_BUSY;
						st_d.ch[i].write = we_i[i];
						st_d.ch[i].addr  = addr_i[i];
						st_d.ch[i].wdata = wdata_i[i];
						st_d.ch[i].cnt   = tcp_pkg::RST_CNT;
					end
				end
				tcp_pkg::TCP_BUSY: begin
					if (st_q.ch[i].cnt == tcp_pkg::CNT_W'(ACCESS_LATENCY - 1)) begin
						st_d.ch[i].state = tcp_pkg::TCP_IDLE;
						st_d.ch[i].rdy   = 1'b1;
						st_d.ch[i].upd   = st_q.ch[i].write;
						if (!st_q.ch[i].write) begin
							st_d.ch[i].rdata = mem[i][st_q.ch[i].addr];
						end
					end else begin
						st_d.ch[i].cnt = tcp_pkg::CNT_W'(st_q.ch[i].cnt + 1'b1);
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers, all on the one port clock
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NC; i++) begin
				st_q.ch[i] <= '{state: tcp_pkg::TCP_IDLE, write: 1'b0, cnt: tcp_pkg::RST_CNT,
					addr: tcp_pkg::RST_ADDR, rdy: 1'b0, rdata: tcp_pkg::RST_DATA,
					upd: 1'b0, wdata: tcp_pkg::RST_DATA};
			end
		end else begin
			st_q <= st_d;
		end
	end

	// The write lands at once so that a read that follows sees it.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NC; i++) begin
			if (st_q.ch[i].state == tcp_pkg::TCP_IDLE && en_i[i] && we_i[i]) begin
				mem[i][addr_i[i]] <= wdata_i[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign cfg.ch0_cfg_ready     = st_q.ch[0].rdy;
	assign cfg.ch1_cfg_ready     = st_q.ch[1].rdy;
	assign cfg.ch0_cfg_read_data = st_q.ch[0].rdata;
	assign cfg.ch1_cfg_read_data = st_q.ch[1].rdata;

	always_comb begin
		for (int i = 0; i < NC; i++) begin
			ch_busy[i]     = (st_q.ch[i].state == tcp_pkg::TCP_BUSY);
			upd_valid[i]   = st_q.ch[i].upd;
			upd_address[i] = st_q.ch[i].addr;
			upd_data[i]    = st_q.ch[i].wdata;
		end
	end

endmodule // tcp_cfg_dev

//--- test/tcp_cfg_monitor.sv
// Checker for the configuration port link between the two ends.
// Assumes the device's default access latency of two busy cycles.
module tcp_cfg_monitor (
	input wire logic                       sys_clk,
	input wire logic                       rst_n,
	input wire logic                       ch0_cfg_access_enable,
	input wire logic                       ch0_cfg_write_select,
	input wire logic [tcp_pkg::ADDR_W-1:0] ch0_cfg_address,
	input wire logic [tcp_pkg::DATA_W-1:0] ch0_cfg_write_data,
	input wire logic [tcp_pkg::DATA_W-1:0] ch0_cfg_read_data,
	input wire logic                       ch0_cfg_ready,
	input wire logic                       ch1_cfg_access_enable,
	input wire logic                       ch1_cfg_write_select,
	input wire logic [tcp_pkg::ADDR_W-1:0] ch1_cfg_address,
	input wire logic [tcp_pkg::DATA_W-1:0] ch1_cfg_write_data,
	input wire logic [tcp_pkg::DATA_W-1:0] ch1_cfg_read_data,
	input wire logic                       ch1_cfg_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_wr_one_cycle: assert property (
		ch0_cfg_access_enable && ch0_cfg_write_select |=> !ch0_cfg_access_enable)
		else $error("ch0 write enable held too long");
	a_dir_needs_en: assert property (
		ch1_cfg_write_select |-> ch1_cfg_access_enable)
		else $error("ch1 write select without enable");
	// Ready is sampled three edges after the edge that samples the enable.
	a_ready_after_en: assert property (
		ch0_cfg_access_enable |-> !ch0_cfg_ready [*3] ##1 ch0_cfg_ready)
		else $error("ch0 ready late");
	a_ready_has_cause: assert property (
		ch1_cfg_ready |-> $past(ch1_cfg_access_enable, 3))
		else $error("ch1 ready without access");
	a_ready_one_pulse: assert property (
		ch1_cfg_ready |=> !ch1_cfg_ready)
		else $error("ch1 ready too long");
	a_rdata_on_read: assert property (
		$changed(ch0_cfg_read_data) |-> ch0_cfg_ready && !$past(ch0_cfg_write_select, 3))
		else $error("ch0 read data moved");
	a_addr_held: assert property (
		ch1_cfg_access_enable |=> $stable(ch1_cfg_address) [*3])
		else $error("ch1 address moved");
	a_wdata_held: assert property (
		ch0_cfg_access_enable |=> $stable(ch0_cfg_write_data) [*3])
		else $error("ch0 write data moved");

	c_write: cover property (ch0_cfg_access_enable && ch0_cfg_write_select ##3 ch0_cfg_ready);
	c_read: cover property (ch0_cfg_access_enable && !ch0_cfg_write_select ##3 ch0_cfg_ready);
	c_ch1: cover property (ch1_cfg_access_enable ##3 ch1_cfg_ready);
endmodule // tcp_cfg_monitor

//--- test/transceiver_config_port_tb.sv
// Bench joining both ends of the configuration port through the interface.
// Assumes one 100 MHz clock shared by both ends and the checker.
`define TCP_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t: got %h want %h", $time, a, b); end end
module transceiver_config_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = tcp_pkg::NUM_CH;
	logic                                     sys_clk = 1'b0;
	logic                                     rst_n = 1'b0;
	logic [N-1:0]                             req_valid = '0, req_ready, req_write = '0;
	logic [N-1:0][tcp_pkg::ADDR_W-1:0]        req_address = '0;
	logic [N-1:0][tcp_pkg::DATA_W-1:0]        req_write_data = '0, resp_read_data, upd_data;
	logic [N-1:0]                             resp_valid, resp_was_write, resp_timeout;
	logic [N-1:0]                             ch_busy, upd_valid;
	logic [N-1:0][tcp_pkg::ADDR_W-1:0]        upd_address;
	int                                       err_count = 0;
	int                                       tests_run = 0;

	tcp_cfg_if cfg_bus ();
	tcp_cfg_dev i_tcp_cfg_dev (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg_bus.dev),
		.ch_busy(ch_busy), .upd_valid(upd_valid), .upd_address(upd_address), .upd_data(upd_data));
	tcp_cfg_host #(.TIMEOUT_CYCLES(8)) i_tcp_cfg_host (.sys_clk(sys_clk), .rst_n(rst_n),
		.cfg(cfg_bus.usr), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_address(req_address), .req_write_data(req_write_data), .resp_valid(resp_valid),
		.resp_was_write(resp_was_write), .resp_timeout(resp_timeout),
		.resp_read_data(resp_read_data));
	tcp_cfg_monitor i_tcp_cfg_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
		.ch0_cfg_access_enable(cfg_bus.ch0_cfg_access_enable),
		.ch0_cfg_write_select(cfg_bus.ch0_cfg_write_select),
		.ch0_cfg_address(cfg_bus.ch0_cfg_address), .ch0_cfg_write_data(cfg_bus.ch0_cfg_write_data),
		.ch0_cfg_read_data(cfg_bus.ch0_cfg_read_data), .ch0_cfg_ready(cfg_bus.ch0_cfg_ready),
		.ch1_cfg_access_enable(cfg_bus.ch1_cfg_access_enable),
		.ch1_cfg_write_select(cfg_bus.ch1_cfg_write_select),
		.ch1_cfg_address(cfg_bus.ch1_cfg_address), .ch1_cfg_write_data(cfg_bus.ch1_cfg_write_data),
		.ch1_cfg_read_data(cfg_bus.ch1_cfg_read_data), .ch1_cfg_ready(cfg_bus.ch1_cfg_ready));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Drives one request and waits for its response; returns in the response cycle,
	// so a following call lands back to back.
	task automatic do_req(input int ch, input logic wr, input logic [9:0] a,
			input logic [15:0] d, input logic [15:0] exp);
		int n;
		logic seen_upd;
		n = 0;
		seen_upd = 1'b0;
		req_valid[ch] = 1'b1;
		req_write[ch] = wr;
		req_address[ch] = a;
		req_write_data[ch] = d;
		@(posedge sys_clk);
		#1;
		req_valid[ch] = 1'b0;
		while (resp_valid[ch] !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (upd_valid[ch] === 1'b1) begin
				seen_upd = 1'b1;
			end
		end
		if (n >= 20) begin
			err_count++;
			$display("BAD %0t: no response", $time);
			finish_test();
		end
		`TCP_CHK(resp_was_write[ch], wr)
		`TCP_CHK(resp_timeout[ch], 1'b0)
		`TCP_CHK(seen_upd, wr)
		if (wr) begin
			`TCP_CHK(upd_address[ch], a)
			`TCP_CHK(upd_data[ch], d)
		end else begin
			`TCP_CHK(resp_read_data[ch], exp)
		end
	endtask

	task automatic t_idle();
		`TCP_CHK(req_ready, 2'h3)
		`TCP_CHK(cfg_bus.ch0_cfg_access_enable, 1'b0)
		`TCP_CHK(resp_valid, 2'h0)
		$display("idle done");
	endtask

	// Writes then reads back at both address limits, back to back.
	task automatic t_bounds();
		do_req(0, 1'b1, 10'h000, 16'ha5c3, 16'h0000);
		do_req(0, 1'b1, 10'h3ff, 16'hffff, 16'h0000);
		do_req(0, 1'b0, 10'h000, 16'h0000, 16'ha5c3);
		do_req(0, 1'b0, 10'h3ff, 16'h0000, 16'hffff);
		$display("bounds done");
	endtask

	// Channel 1 has its own space: the same address keeps channel 1's value after channel 0 writes it.
	task automatic t_channels();
		do_req(1, 1'b1, 10'h155, 16'h1234, 16'h0000);
		do_req(0, 1'b1, 10'h155, 16'h00ff, 16'h0000);
		do_req(1, 1'b0, 10'h155, 16'h0000, 16'h1234);
		do_req(0, 1'b0, 10'h155, 16'h0000, 16'h00ff);
		$display("channels done");
	endtask

	// A request offered while busy must be dropped, not stored.
	task automatic t_refused();
		req_valid[0] = 1'b1;
		req_write[0] = 1'b1;
		req_address[0] = 10'h2aa;
		req_write_data[0] = 16'h5a5a;
		@(posedge sys_clk);
		#1;
		req_write_data[0] = 16'hdead;
		`TCP_CHK(req_ready[0], 1'b0)
		@(posedge sys_clk);
		#1;
		`TCP_CHK(ch_busy[0], 1'b1)
		req_valid[0] = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		do_req(0, 1'b0, 10'h2aa, 16'h0000, 16'h5a5a);
		$display("refused done");
	endtask

	initial begin
		repeat (8) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		t_idle();
		t_bounds();
		t_channels();
		t_refused();
		finish_test();
	end
endmodule // transceiver_config_port_tb
